//--- rtl/otp_programmer.sv
// host controller that reads, programs and identifies the memory
`timescale 1ns/10ps
`include "otp_consts.svh"
module otp_programmer (
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          cmd_valid,
  input  otp_pkg::cmd_t      cmd,
  input  otp_pkg::req_t      req,
  output logic               cmd_ready,
  output logic               rsp_valid,
  output otp_pkg::rsp_t      rsp,
  output otp_pkg::pins_t     pins,
  input  wire logic [7:0]    data_in
);
  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    otp_pkg::state_t st;
    otp_pkg::cmd_t   cmd;
    otp_pkg::req_t   req;
    logic [15:0]     cnt;
    logic [4:0]      pulses;
    logic            ready;
    logic            rvalid;
    otp_pkg::rsp_t   rsp;
    otp_pkg::pins_t  pins;
  } all_t;

  all_t s_q, s_d;
  logic [7:0] din;

  pin_sync #(.W(8)) u_sync (
    .clock (clock),
    .srst  (srst),
    .pin   (data_in),
    .q     (din)
  );

  localparam logic [15:0] PULSE_CYC = 16'(`PULSE_CYC);
  localparam logic [15:0] SETUP_CYC = 16'(`SETUP_CYC);
  localparam logic [15:0] ACC_CYC   = 16'(`ACC_CYC + `SYNC_CYC);
  localparam logic [15:0] DV_CYC    = 16'(`DV_CYC + `SYNC_CYC);
  localparam logic [15:0] FLOAT_CYC = 16'(`FLOAT_CYC);

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    case (s_q.st)
      otp_pkg::S_IDLE: begin
        s_d.ready = 1'b1;
        if (cmd_valid && s_q.ready) begin
          s_d.ready  = 1'b0;
          s_d.cmd    = cmd;
          s_d.req    = req;
          s_d.pulses = 5'h00;
          s_d.cnt    = 16'h0000;
          s_d.pins.address_lines = req.addr;
          s_d.pins.data_oe_n = 1'b1;
          s_d.pins.gate_n = 1'b1;
          s_d.pins.select_n = 1'b1;
          s_d.st = otp_pkg::S_ACCESS;
          if (cmd == otp_pkg::CMD_PROGRAM) begin
            // program voltage on, data driven, select still high
            s_d.pins.vpp_on    = 1'b1;
            s_d.pins.data_out  = req.data;
            s_d.pins.data_oe_n = 1'b0;
            s_d.st = otp_pkg::S_SETUP;
          end else if (cmd == otp_pkg::CMD_IDENT) begin
            // only line zero may differ from low
            s_d.pins.address_lines =
              {15'h0000, req.addr[0]};
            s_d.pins.id_trigger_hv = 1'b1;
            s_d.pins.select_n = 1'b0;
            s_d.pins.gate_n   = 1'b0;
          end else begin
            s_d.pins.select_n = 1'b0;
            s_d.pins.gate_n   = 1'b0;
          end
        end
      end
      otp_pkg::S_SETUP: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        // after a failed verify the memory may still drive the lines,
        // so data goes on only after its float delay; setup stays 2 us
        if (s_q.cnt == FLOAT_CYC - 16'h0001) begin
          s_d.pins.data_oe_n = 1'b0;
        end
        if (s_q.cnt == SETUP_CYC + FLOAT_CYC - 16'h0001) begin
          s_d.cnt = 16'h0000;
          s_d.pins.select_n = 1'b0;
          s_d.pulses = s_q.pulses + 5'h01;
          s_d.st = otp_pkg::S_PULSE;
        end
      end
      otp_pkg::S_PULSE: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        // 100 us sits inside the 95..105 us window
        if (s_q.cnt == PULSE_CYC - 16'h0001) begin
          s_d.cnt = 16'h0000;
          s_d.pins.select_n = 1'b1;
          s_d.st = otp_pkg::S_HOLD;
        end
      end
      otp_pkg::S_HOLD: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == SETUP_CYC - 16'h0001) begin
          // release data, drop program voltage before verify
          s_d.cnt = 16'h0000;
          s_d.pins.data_oe_n = 1'b1;
          s_d.pins.vpp_on = 1'b0;
          s_d.st = otp_pkg::S_VSETUP;
        end
      end
      otp_pkg::S_VSETUP: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == SETUP_CYC - 16'h0001) begin
          s_d.cnt = 16'h0000;
          s_d.pins.select_n = 1'b0;
          s_d.pins.gate_n   = 1'b0;
          s_d.st = otp_pkg::S_VREAD;
        end
      end
      otp_pkg::S_VREAD: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        // wait covers data valid time plus synchroniser latency
        if (s_q.cnt == DV_CYC - 16'h0001) begin
          s_d.cnt = 16'h0000;
          s_d.pins.select_n = 1'b1;
          s_d.pins.gate_n   = 1'b1;
          s_d.rsp.data = din;
          if (din == s_q.req.data ||
              s_q.pulses == `MAX_PULSES) begin
            s_d.rsp.ok = (din == s_q.req.data);
            s_d.rsp.pulses = s_q.pulses;
            s_d.st = otp_pkg::S_FLOAT;
          end else begin
            // retry: program voltage on, data waits in setup
            s_d.pins.vpp_on    = 1'b1;
            s_d.st = otp_pkg::S_SETUP;
          end
        end
      end
      otp_pkg::S_ACCESS: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        if (s_q.cnt == ACC_CYC - 16'h0001) begin
          s_d.cnt = 16'h0000;
          s_d.rsp.data = din;
          s_d.rsp.pulses = 5'h00;
          s_d.rsp.ok = (s_q.cmd != otp_pkg::CMD_CHECK) ||
                       (din == s_q.req.data);
          if (s_q.cmd == otp_pkg::CMD_IDENT) begin
            s_d.rsp.ok = ^din;
          end
          s_d.pins.select_n = 1'b1;
          s_d.pins.gate_n   = 1'b1;
          s_d.st = otp_pkg::S_FLOAT;
        end
      end
      otp_pkg::S_FLOAT: begin
        s_d.cnt = s_q.cnt + 16'h0001;
        // device may still drive the bus just after select rises
        if (s_q.cnt == FLOAT_CYC) begin
          s_d.cnt = 16'h0000;
          s_d.pins.id_trigger_hv = 1'b0;
          s_d.rvalid = 1'b1;
          s_d.st = otp_pkg::S_DONE;
        end
      end
      otp_pkg::S_DONE: begin
        s_d.st = otp_pkg::S_IDLE;
      end
      default: begin
        s_d.st = otp_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s_q <= '0;
      s_q.pins.select_n  <= 1'b1;
      s_q.pins.gate_n    <= 1'b1;
      s_q.pins.data_oe_n <= 1'b1;
      s_q.st <= otp_pkg::S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign cmd_ready = s_q.ready;
  assign rsp_valid = s_q.rvalid;
  assign rsp       = s_q.rsp;
  assign pins      = s_q.pins;

  // ==========================================================
  // assertions
  // ==========================================================
  sequence pulse_start_s;
    $fell(pins.select_n) && pins.vpp_on;
  endsequence

  pulse_width_a: assert property (@(posedge clock) disable iff (srst)
    pulse_start_s |-> pins.vpp_on throughout
      (s_q.st == otp_pkg::S_PULSE)[*8])
    else $error("program pulse shorter than expected");

  pulse_cap_a: assert property (@(posedge clock) disable iff (srst)
    s_q.pulses <= `MAX_PULSES)
    else $error("more than the allowed pulses");

  verify_gate_a: assert property (@(posedge clock) disable iff (srst)
    (s_q.st == otp_pkg::S_VREAD) |->
      !pins.select_n && !pins.gate_n && !pins.vpp_on)
    else $error("verify without select and gate low");

  no_clash_a: assert property (@(posedge clock) disable iff (srst)
    !pins.data_oe_n |-> pins.vpp_on)
    else $error("host drives data outside program mode");

  ident_addr_a: assert property (@(posedge clock) disable iff (srst)
    pins.id_trigger_hv |->
      pins.address_lines[15:1] == 15'h0000)
    else $error("identifier address not low");

  prog_entry_a: assert property (@(posedge clock) disable iff (srst)
    (s_q.st == otp_pkg::S_PULSE) |->
      !pins.select_n && pins.vpp_on && !pins.data_oe_n)
    else $error("pulse without program conditions");

  rsp_pulse_a: assert property (@(posedge clock) disable iff (srst)
    rsp_valid |=> !rsp_valid ##1 cmd_ready)
    else $error("response not a single pulse");

  vpp_select_a: assert property (@(posedge clock) disable iff (srst)
    $rose(pins.vpp_on) |-> pins.select_n ##1 pins.select_n)
    else $error("select low while program voltage rises");
endmodule

//--- rtl/otp_consts.svh
// constants for the one-time-programmable memory programmer
`ifndef OTP_CONSTS_SVH
`define OTP_CONSTS_SVH
`define CLK_MHZ          250
`define ADDR_W           16
`define DATA_W           8
`define LAST_ADDR        16'hffff
`define MAX_PULSES       5'h19
`define PULSE_US         100
`define PULSE_CYC        (`PULSE_US * `CLK_MHZ)
`define SETUP_US         2
`define SETUP_CYC        (`SETUP_US * `CLK_MHZ)
`define ACC_NS           70
`define ACC_CYC          ((`ACC_NS * `CLK_MHZ + 999) / 1000)
`define DV_NS            150
`define DV_CYC           ((`DV_NS * `CLK_MHZ + 999) / 1000)
`define FLOAT_NS         130
`define FLOAT_CYC        ((`FLOAT_NS * `CLK_MHZ + 999) / 1000)
`define SYNC_CYC         4
`define ID_ADDR_MFR      16'h0000
`define ID_ADDR_DEV      16'h0001
`define ID_TRIGGER_BIT   9
`define PARITY_BIT       7
`endif

//--- rtl/otp_pkg.sv
// types for the memory programmer
package otp_pkg;
  typedef enum logic [2:0] {
    CMD_READ, CMD_PROGRAM, CMD_IDENT, CMD_CHECK
  } cmd_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } req_t;

  typedef struct packed {
    logic [7:0] data;
    logic       ok;
    logic [4:0] pulses;
  } rsp_t;

  // pins toward the memory; oe low means this side drives
  typedef struct packed {
    logic [15:0] address_lines;
    logic        select_n;
    logic        gate_n;
    logic        vpp_on;
    logic        id_trigger_hv;
    logic [7:0]  data_out;
    logic        data_oe_n;
  } pins_t;

  typedef enum logic [3:0] {
    S_IDLE, S_SETUP, S_PULSE, S_HOLD, S_VSETUP, S_VREAD,
    S_ACCESS, S_FLOAT, S_DONE
  } state_t;
endpackage

//--- rtl/pin_sync.sv
// three-flop synchroniser with agreement check for pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_t;

  sync_t        r_q, r_d;
  logic [W-1:0] pick;

  // a bit moves only when the last two stages agree, so a line that
  // toggles while floating never reaches the output
  for (genvar i = 0; i < W; i++) begin : g_bit
    assign pick[i] = (r_q.s2[i] == r_q.s3[i]) ? r_q.s3[i] : r_q.q[i];
  end

  // first stage feeds only the second
  always_comb begin
    r_d    = r_q;
    r_d.s1 = pin;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.q  = pick;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end
  assign q = r_q.q;
endmodule

//--- bench/otp_memory_model.sv
// behavioural model of the one-time-programmable memory
`timescale 1ns/10ps
module otp_memory_model #(
  parameter logic [7:0] MFR_CODE = 8'h83, // arbitrary value, odd parity
  parameter logic [7:0] DEV_CODE = 8'h07  // arbitrary value, odd parity
) (
  input  wire logic        clock,
  input  otp_pkg::pins_t   pins,
  input  wire logic [4:0]  pulses_needed,
  output logic      [7:0]  data_in,
  output logic      [15:0] last_width,
  output logic             viol
);
  logic [7:0]  mem [65536];
  logic [4:0]  hits [65536];
  logic [15:0] width;
  logic [7:0]  last_q;
  logic [7:0]  word;
  logic        reading_q;
  logic        low_q;
  // ==========================================
  // storage, blank state
  initial begin
    foreach (mem[i]) begin
      mem[i] = 8'hff;
      hits[i] = 5'h00;
    end
    viol = 1'b0;
    last_width = 16'h0000;
  end
  // ==========================================
  // pin decode
  always_comb begin
    if (pins.id_trigger_hv) begin
      word = pins.address_lines[0] ? DEV_CODE : MFR_CODE;
    end else begin
      word = mem[pins.address_lines];
    end
  end
  // floating lines show a changing pattern, not the last byte
  assign data_in = !pins.data_oe_n ? pins.data_out :
                   reading_q ? word : ~last_q;
  always @(posedge clock) begin
    last_q <= data_in;
    // one cycle from gate low to data stands in for the output delay
    reading_q <= !pins.select_n && !pins.gate_n && !pins.vpp_on;
    low_q <= !pins.select_n && pins.vpp_on;
    width <= (!pins.select_n && pins.vpp_on) ? width + 16'h0001 : 16'h0000;
    if (reading_q && !pins.data_oe_n) begin
      viol <= 1'b1;
    end
    if (pins.id_trigger_hv &&
        (pins.address_lines & 16'hfdfe) != 16'h0000) begin
      viol <= 1'b1;
    end
    if (low_q && pins.select_n && pins.vpp_on) begin
      last_width <= width;
      if (width < 16'h5cc6 || width > 16'h668a || pins.data_oe_n) begin
        viol <= 1'b1;
      end
      hits[pins.address_lines] <= hits[pins.address_lines] + 5'h01;
      if (hits[pins.address_lines] >= 5'h19) begin
        viol <= 1'b1;
      end
      if (hits[pins.address_lines] + 5'h01 >= pulses_needed) begin
        mem[pins.address_lines] <=
          mem[pins.address_lines] & pins.data_out;
      end
    end
  end
endmodule

//--- bench/otp_programmer_tb_top.sv
// self-checking bench for the memory programmer
`timescale 1ns/10ps
module otp_programmer_tb_top;
  logic           clock;
  logic           srst;
  logic           cmd_valid;
  logic           cmd_ready;
  logic           rsp_valid;
  logic           viol;
  otp_pkg::cmd_t  cmd;
  otp_pkg::req_t  req;
  otp_pkg::rsp_t  rsp;
  otp_pkg::rsp_t  got;
  otp_pkg::pins_t pins;
  logic [7:0]     data_in;
  logic [4:0]     need;
  logic [15:0]    pw;
  int             bad_count;
  int             comparisons;

  otp_programmer dut (.clock(clock), .srst(srst), .cmd_valid(cmd_valid),
    .cmd(cmd), .req(req), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp(rsp), .pins(pins), .data_in(data_in));
  otp_memory_model mem0 (.clock(clock), .pins(pins), .pulses_needed(need),
    .data_in(data_in), .last_width(pw), .viol(viol));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========================================
  // shared tasks
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // long bound covers two program pulses and their setup intervals
  task automatic run_cmd(otp_pkg::cmd_t c, logic [15:0] a, logic [7:0] d);
    int n;
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd = c;
    req = '{addr: a, data: d};
    for (n = 0; cmd_ready !== 1'b1 && n < 100; n++) @(negedge clock);
    if (n >= 100) begin
      $display("ERROR cmd_ready expected 1 seen 0");
      bad_count++;
      tally_and_finish();
    end
    @(negedge clock);
    cmd_valid = 1'b0;
    for (n = 0; rsp_valid !== 1'b1 && n < 80000; n++) @(negedge clock);
    if (n >= 80000) begin
      $display("ERROR rsp_valid expected 1 seen 0");
      bad_count++;
      tally_and_finish();
    end
    got = rsp;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    repeat (20) @(negedge clock);
    check("select_n", pins.select_n, 1'b1);
    check("gate_n", pins.gate_n, 1'b1);
    check("vpp_on", pins.vpp_on, 1'b0);
    check("data_oe_n", pins.data_oe_n, 1'b1);
    check("id_trigger_hv", pins.id_trigger_hv, 1'b0);
    srst = 1'b0;
    $display("test reset done");
  endtask
  task automatic t_read_blank();
    run_cmd(otp_pkg::CMD_READ, 16'h1234, 8'h00);
    check("blank data", got.data, 8'hff);
    check("read ok", got.ok, 1'b1);
    run_cmd(otp_pkg::CMD_READ, 16'hffff, 8'h00);
    check("top data", got.data, 8'hff);
    $display("test read done");
  endtask
  task automatic t_ident();
    run_cmd(otp_pkg::CMD_IDENT, 16'h0000, 8'h00);
    check("maker byte", got.data, 8'h83);
    check("maker parity", got.ok, 1'b1);
    run_cmd(otp_pkg::CMD_IDENT, 16'h0001, 8'h00);
    check("part byte", got.data, 8'h07);
    check("part parity", got.ok, 1'b1);
    $display("test ident done");
  endtask
  task automatic t_program();
    need = 5'h02;
    run_cmd(otp_pkg::CMD_PROGRAM, 16'h0042, 8'h5a);
    check("pulses", got.pulses, 5'h02);
    check("prog ok", got.ok, 1'b1);
    check("width ok", pw >= 16'h5cc6 && pw <= 16'h668a, 1'b1);
    run_cmd(otp_pkg::CMD_READ, 16'h0042, 8'h00);
    check("stored", got.data, 8'h5a);
    run_cmd(otp_pkg::CMD_READ, 16'h0043, 8'h00);
    check("neighbour", got.data, 8'hff);
    $display("test program done");
  endtask
  task automatic t_verify();
    run_cmd(otp_pkg::CMD_CHECK, 16'h0042, 8'h5a);
    check("match", got.ok, 1'b1);
    run_cmd(otp_pkg::CMD_CHECK, 16'h0042, 8'h5b);
    check("mismatch", got.ok, 1'b0);
    check("pin rules", viol, 1'b0);
    $display("test verify done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd = otp_pkg::CMD_READ;
    req = '0;
    need = 5'h01;
    bad_count = 0;
    comparisons = 0;
    t_reset();
    t_read_blank();
    t_ident();
    t_program();
    t_verify();
    tally_and_finish();
  end
endmodule
